/* design/pbcp_defs.svh */
// Constants of the bias and charge pump configuration registers.
// Assumes inclusion by bare name from the package and design files.
`ifndef PBCP_DEFS_SVH
`define PBCP_DEFS_SVH
`define PBCP_ADDR_ANALOG_EN     6'h08
`define PBCP_ADDR_PUMP          6'h09
`define PBCP_ADDR_OUTPUT_CFG    6'h0f
`define PBCP_ANALOG_EN_RESET    24'hc1_beff
`define PBCP_PUMP_RESET         24'h40_3264
`define PBCP_OUTPUT_CFG_RESET   24'h00_0000
`define PBCP_BIT_PAD_EN         5
`define PBCP_BIT_OUT_ALWAYS     7
`define PBCP_BIT_LOCK_SHOW_N    6
`define PBCP_BIT_HF_REF         21
`define PBCP_BIT_VCO_BIAS       10
`define PBCP_BIT_PRESC_CLK      9
`define PBCP_DN_LSB             0
`define PBCP_UP_LSB             7
`define PBCP_OFS_LSB            14
`define PBCP_BIT_OFS_UP         21
`define PBCP_BIT_OFS_DN         22
`define PBCP_SCK_DIV            16'h0004
// Host APB register byte offsets.
`define PBCP_APB_CTRL           12'h000
`define PBCP_APB_WDATA          12'h004
`define PBCP_APB_RDATA          12'h008
`define PBCP_APB_STATUS         12'h00c
`endif

/* design/pbcp_device.sv */
// Device end: bias enable and charge pump configuration registers on the serial port.
// Assumes sck, sen and sdi are synchronous to pclk (sck is a sampled level).
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "pbcp_defs.svh"
module pbcp_device
    import pbcp_pkg::*;
#(
    parameter logic [2:0] CHIP_ADDR = 3'h0
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    pbcp_if.device           link,
    input  wire logic        lock_flag,
    output logic             vco_bias_en,
    output logic             prescaler_clk_en,
    output logic             high_freq_ref,
    output logic [6:0]       pump_down_gain,
    output logic [6:0]       pump_up_gain,
    output logic [6:0]       offset_magnitude,
    output logic             offset_up_en,
    output logic             offset_dn_en,
    output logic             lock_or_serial_out_pin,
    output logic             serial_out_driver
);
    // Register file and serial shift state.
    logic [23:0] analog_bias_enable;
    logic [23:0] charge_pump_control;
    logic [23:0] output_config;
    logic [33:0] shreg;
    logic [5:0]  bit_cnt;
    logic        sck_q;
    logic        sen_q;
    logic        reading;
    logic        addr_match;
    logic        match_seen;
    logic [23:0] rd_word;
    logic        sdo_q;
    logic        oe_q;

    // Edge and frame detection on the sampled link levels.
    wire sck_rise   = link.sck & ~sck_q;
    wire sck_fall   = ~link.sck & sck_q;
    wire frame_end  = sen_q & ~link.sen;
    wire frame_full = (bit_cnt == 6'd34);
    wire hdr_done   = (bit_cnt == 6'd10);

    // Header fields, valid while exactly ten bits have arrived.
    wire       hdr_write = shreg[9];
    wire [5:0] hdr_reg   = shreg[8:3];
    wire [2:0] hdr_chip  = shreg[2:0];
    wire       hdr_match = (hdr_chip == CHIP_ADDR);

    // Fields of a complete frame.
    wire        f_write = shreg[33];
    wire [5:0]  f_reg   = shreg[32:27];
    wire [23:0] f_data  = shreg[23:0];

    // A write lands only at the end of a complete frame for this chip, so a cut
    // frame leaves every register as it was.
    wire wr_commit = frame_end && f_write && frame_full && addr_match;
    wire wr_analog = wr_commit && (f_reg == `PBCP_ADDR_ANALOG_EN);
    wire wr_pump   = wr_commit && (f_reg == `PBCP_ADDR_PUMP);
    wire wr_outcfg = wr_commit && (f_reg == `PBCP_ADDR_OUTPUT_CFG);

    // Pin control bits.
    wire pad_en     = analog_bias_enable[`PBCP_BIT_PAD_EN];
    wire out_always = output_config[`PBCP_BIT_OUT_ALWAYS];
    wire lock_view  = ~output_config[`PBCP_BIT_LOCK_SHOW_N];

    // Read word for a register address; unknown addresses read as zero.
    function automatic logic [23:0] pbcp_select(input logic [5:0] a, input logic [23:0] an,
                                                input logic [23:0] cp, input logic [23:0] oc);
        case (a)
            `PBCP_ADDR_ANALOG_EN:  pbcp_select = an;
            `PBCP_ADDR_PUMP:       pbcp_select = cp;
            `PBCP_ADDR_OUTPUT_CFG: pbcp_select = oc;
            default:               pbcp_select = 24'h00_0000;
        endcase
    endfunction

    // Shift register: bits arrive MSB first on sck rising edges while sen is high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shreg   <= '0;
            bit_cnt <= '0;
            sck_q   <= 1'b0;
            sen_q   <= 1'b0;
        end else begin
            sck_q <= link.sck;
            sen_q <= link.sen;
            if (!link.sen) begin
                bit_cnt <= '0;
            end else if (sck_rise && !frame_full) begin
                shreg   <= {shreg[32:0], link.sdi};
                bit_cnt <= bit_cnt + 6'd1;
            end
        end
    end

    // Header decode: match and read state are fixed once ten header bits are in.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reading    <= 1'b0;
            addr_match <= 1'b0;
            match_seen <= 1'b0;
            rd_word    <= '0;
        end else if (!link.sen) begin
            reading    <= 1'b0;
            match_seen <= 1'b0;
        end else if (hdr_done && !match_seen) begin
            match_seen <= 1'b1;
            addr_match <= hdr_match;
            reading    <= ~hdr_write && hdr_match;
            rd_word    <= pbcp_select(hdr_reg, analog_bias_enable,
                                      charge_pump_control, output_config);
        end else if (reading && sck_fall && !hdr_done) begin
            // The fall that ends the last header bit leaves the MSB in place, so that
            // it stands through the whole of the first data bit.
            rd_word <= {rd_word[22:0], 1'b0};
        end
    end

    // Analog enable register, reserved bits included.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_bias_enable <= `PBCP_ANALOG_EN_RESET;
        end else if (wr_analog) begin
            analog_bias_enable <= f_data;
        end
    end

    // Charge pump register; the reserved top bit is stored like the rest.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charge_pump_control <= `PBCP_PUMP_RESET;
        end else if (wr_pump) begin
            charge_pump_control <= f_data;
        end
    end

    // Output configuration register, kept here because the pin logic needs two of its bits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_config <= `PBCP_OUTPUT_CFG_RESET;
        end else if (wr_outcfg) begin
            output_config <= f_data;
        end
    end

    // Driver enable: an unmatched frame releases the pin from the end of its header
    // until sen falls, unless the pin is forced on for the output port.
    wire unmatched = link.sen && match_seen && !addr_match;
    wire next_oe   = pad_en && (out_always || !unmatched);
    wire next_sdo  = (reading || !lock_view) ? rd_word[23] : lock_flag;

    // Pin value and enable are registered so the shared line never glitches.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdo_q <= 1'b0;
            oe_q  <= 1'b0;
        end else begin
            sdo_q <= next_sdo;
            oe_q  <= next_oe;
        end
    end

    // Configuration outputs follow their register bits one clock later.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_bias_en      <= 1'b0;
            prescaler_clk_en <= 1'b0;
            high_freq_ref    <= 1'b0;
            pump_down_gain   <= '0;
            pump_up_gain     <= '0;
            offset_magnitude <= '0;
            offset_up_en     <= 1'b0;
            offset_dn_en     <= 1'b0;
        end else begin
            vco_bias_en      <= analog_bias_enable[`PBCP_BIT_VCO_BIAS];
            prescaler_clk_en <= analog_bias_enable[`PBCP_BIT_PRESC_CLK];
            high_freq_ref    <= analog_bias_enable[`PBCP_BIT_HF_REF];
            pump_down_gain   <= charge_pump_control[`PBCP_DN_LSB +: 7];
            pump_up_gain     <= charge_pump_control[`PBCP_UP_LSB +: 7];
            offset_magnitude <= charge_pump_control[`PBCP_OFS_LSB +: 7];
            offset_up_en     <= charge_pump_control[`PBCP_BIT_OFS_UP];
            offset_dn_en     <= charge_pump_control[`PBCP_BIT_OFS_DN];
        end
    end

    assign link.sdo_out           = sdo_q;
    assign link.sdo_oe            = oe_q;
    assign lock_or_serial_out_pin = sdo_q;
    assign serial_out_driver      = oe_q;
endmodule
`default_nettype wire

/* design/pbcp_host.sv */
// Host end: APB slave that runs one serial frame per software request.
// Assumes APB and the link share pclk; the device answers on sdo.
`timescale 1ns/1ps
`default_nettype none
`include "pbcp_defs.svh"
module pbcp_host
    import pbcp_pkg::*;
#(
    parameter logic [15:0] SCK_DIV = `PBCP_SCK_DIV
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    pbcp_if.host             link
);
    pbcp_state_t state;
    logic [33:0] frame;
    logic [33:0] ctrl_word;
    logic [23:0] wdata;
    logic [23:0] rdata;
    logic [5:0]  bits_left;
    logic [15:0] div_cnt;
    logic        sen_q;
    logic        sck_q;
    logic        done_flag;

    wire tick      = (div_cnt == SCK_DIV - 16'd1);
    wire apb_wr    = psel && penable && pwrite;
    wire hit_ctrl  = (paddr == `PBCP_APB_CTRL);
    wire hit_wdata = (paddr == `PBCP_APB_WDATA);
    wire known     = hit_ctrl || hit_wdata || paddr == `PBCP_APB_RDATA
                     || paddr == `PBCP_APB_STATUS;
    // CTRL: bit 9 write flag, bits 8:3 register address, bits 2:0 chip address.
    wire start     = apb_wr && hit_ctrl && state == PBCP_IDLE;
    wire busy      = state != PBCP_IDLE;
    wire [31:0] rd_mux = (paddr == `PBCP_APB_RDATA)  ? {8'h00, rdata} :
                         (paddr == `PBCP_APB_WDATA)  ? {8'h00, wdata} :
                         (paddr == `PBCP_APB_STATUS) ? {30'h0000_0000, done_flag, busy} :
                         32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            wdata   <= '0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !known;
            prdata  <= rd_mux;
            if (apb_wr && hit_wdata && pready) begin
                wdata <= pwdata[23:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= PBCP_IDLE;
            frame     <= '0;
            bits_left <= '0;
            div_cnt   <= '0;
            sen_q     <= 1'b0;
            sck_q     <= 1'b0;
            rdata     <= '0;
            done_flag <= 1'b0;
        end else begin
            div_cnt <= (busy && !tick) ? div_cnt + 16'd1 : 16'd0;
            case (state)
                PBCP_IDLE: begin
                    if (start && pready) begin
                        frame     <= {pwdata[9:0], wdata};
                        bits_left <= 6'd34;
                        sen_q     <= 1'b1;
                        done_flag <= 1'b0;
                        state     <= PBCP_SHIFT;
                    end
                end
                PBCP_SHIFT: begin
                    if (tick) begin
                        if (!sck_q && bits_left == 6'd0) begin
                            state <= PBCP_DONE;
                        end else if (!sck_q) begin
                            sck_q <= 1'b1;
                        end else begin
                            sck_q     <= 1'b0;
                            frame     <= {frame[32:0], 1'b0};
                            rdata     <= {rdata[22:0], link.sdo_pin};
                            bits_left <= bits_left - 6'd1;
                        end
                    end
                end
                PBCP_DONE: begin
                    sen_q     <= 1'b0;
                    done_flag <= 1'b1;
                    state     <= PBCP_IDLE;
                end
                default: state <= PBCP_IDLE;
            endcase
        end
    end

    assign ctrl_word = frame;
    assign link.sen  = sen_q;
    assign link.sck  = sck_q;
    assign link.sdi  = ctrl_word[33];
endmodule
`default_nettype wire

/* design/pbcp_if.sv */
// Serial programming link between host controller and device.
// Assumes both ends share pclk; the pin level is resolved here.
`timescale 1ns/1ps
`default_nettype none
interface pbcp_if;
    logic sen;
    logic sck;
    logic sdi;
    logic sdo_out;
    logic sdo_oe;
    wire  sdo_pin;
    // There is no pull-up on the line, so a released pin shows the inverse of the
    // current sdo_out level; a reader that samples it anyway gets a wrong bit.
    assign sdo_pin = sdo_oe ? sdo_out : ~sdo_out;
    modport device (input sen, input sck, input sdi, output sdo_out, output sdo_oe);
    modport host (output sen, output sck, output sdi, input sdo_pin);
endinterface
`default_nettype wire

/* design/pbcp_pkg.sv */
// Types shared by both ends of the serial configuration link.
// Assumes the constants header is on the include path.
`include "pbcp_defs.svh"
package pbcp_pkg;
    typedef enum logic [1:0] {
        PBCP_IDLE,
        PBCP_SHIFT,
        PBCP_DONE
    } pbcp_state_t;
    // Frame: write flag, 6-bit register address, 3-bit chip address, 24 data bits.
    localparam int PBCP_FRAME_BITS = 34;
endpackage

/* testbench/pbcp_link_sva.sv */
// Checker of the serial link and the device configuration outputs.
// Assumes one pclk domain, SCK_DIV of 4 and chip address zero.
`timescale 1ns/1ps
`default_nettype none
module pbcp_link_sva (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       sen,
    input wire logic       sck,
    input wire logic       sdi,
    input wire logic       sdo_out,
    input wire logic       sdo_oe,
    input wire logic       lock_flag,
    input wire logic       serial_out_driver,
    input wire logic       vco_bias_en,
    input wire logic [6:0] pump_down_gain,
    input wire logic [6:0] pump_up_gain,
    input wire logic [6:0] offset_magnitude,
    input wire logic       offset_dn_en
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_sck_high;
        sck [*4] ##1 !sck;
    endsequence
    sequence s_idle_lock;
        (!sen && $stable(lock_flag)) [*3];
    endsequence
    sequence s_frame_just_ended;
        $past(sen) || $past(sen, 2) || $past(sen, 3);
    endsequence
    AST_RST_GAIN: assert property ($rose(presetn) |-> ##2 vco_bias_en &&
        pump_down_gain == 7'h64 && pump_up_gain == 7'h64 && offset_magnitude == 7'h0)
        else $error("gains differ from reset defaults");
    AST_RST_DIR: assert property ($rose(presetn) |-> ##2 offset_dn_en)
        else $error("downward leakage not enabled after reset");
    AST_OE_AFTER_HDR: assert property ($fell(serial_out_driver) && sen |-> $past(sen, 8))
        else $error("driver released before the frame header");
    AST_LOCK_IDLE: assert property (s_idle_lock |-> sdo_out == lock_flag)
        else $error("pin does not show lock outside frames");
    AST_GAIN_AFTER_FRAME: assert property ($changed(pump_down_gain) && $past(presetn, 3)
        |-> !sen and s_frame_just_ended) else $error("gain moved outside a frame end");
    AST_OE_WITH_FRAME: assert property ($changed(sdo_oe) && $past(presetn, 3)
        |-> sen or s_frame_just_ended) else $error("driver moved away from a frame");
    AST_SCK_HIGH: assert property ($rose(sck) |-> s_sck_high)
        else $error("serial clock high time wrong");
    AST_SDI_STABLE: assert property ($rose(sck) |-> $stable(sdi))
        else $error("data moved at serial clock rise");
endmodule
`default_nettype wire

/* testbench/test_pll_bias_charge_pump_config_regs.sv */
// Bench joining host and device over the link, driven through APB.
// Assumes a 40 MHz pclk and the device chip address of zero.
`timescale 1ns/1ps
`default_nettype none
`include "pbcp_defs.svh"
module test_pll_bias_charge_pump_config_regs;
    import pbcp_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lock_flag = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, err, vco_bias_en, prescaler_clk_en, high_freq_ref;
    logic [6:0]  pump_down_gain, pump_up_gain, offset_magnitude;
    logic        offset_up_en, offset_dn_en, lock_or_serial_out_pin, serial_out_driver;
    int          err_count = 0, total_checks = 0, rel_cnt = 0, c0;
    logic [29:0] rows [5] = '{{6'h09, 24'hff_ffff}, {6'h09, 24'h20_0080},
        {6'h09, 24'h1f_c07f}, {6'h08, 24'h3e_4320}, {6'h08, 24'hc1_beff}};
    pbcp_if pbcp_if_inst ();
    pbcp_host pbcp_host_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .link(pbcp_if_inst));
    pbcp_device pbcp_device_inst (.pclk, .presetn, .link(pbcp_if_inst), .lock_flag,
        .vco_bias_en, .prescaler_clk_en, .high_freq_ref, .pump_down_gain, .pump_up_gain,
        .offset_magnitude, .offset_up_en, .offset_dn_en, .lock_or_serial_out_pin,
        .serial_out_driver);
    pbcp_link_sva pbcp_link_sva_inst (.pclk, .presetn, .sen(pbcp_if_inst.sen),
        .sck(pbcp_if_inst.sck), .sdi(pbcp_if_inst.sdi), .sdo_out(pbcp_if_inst.sdo_out),
        .sdo_oe(pbcp_if_inst.sdo_oe), .lock_flag, .serial_out_driver, .vco_bias_en,
        .pump_down_gain, .pump_up_gain, .offset_magnitude, .offset_dn_en);
    always #12.5 pclk = ~pclk;
    // Counts cycles in which the device has let go of the shared line mid-frame.
    always @(posedge pclk) begin
        if (pbcp_if_inst.sen && !pbcp_if_inst.sdo_oe)
            rel_cnt <= rel_cnt + 1;
    end
    task automatic wrap_up();
        if (err_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        chk("pready", pready, 1);
        if (pready !== 1'b1)
            wrap_up();
        @(posedge pclk);
    endtask
    // A read frame leaves the answer in rd; busy is polled with a bound.
    task automatic frame(input logic w, input logic [5:0] r, input logic [2:0] c,
                         input logic [23:0] d);
        int n;
        n = 0;
        apb(1, `PBCP_APB_WDATA, {8'h00, d});
        apb(1, `PBCP_APB_CTRL, {22'h0, w, r, c});
        do begin
            apb(0, `PBCP_APB_STATUS, 0);
            n++;
        end while (rd[0] !== 1'b0 && n < 400);
        chk("busy", rd[0], 0);
        if (rd[0] !== 1'b0)
            wrap_up();
        if (!w)
            apb(0, `PBCP_APB_RDATA, 0);
    endtask
    task automatic rst();
        presetn <= 0;
        repeat (6) @(posedge pclk);
        presetn <= 1;
        repeat (3) @(posedge pclk);
        chk("rst_bits", {vco_bias_en, prescaler_clk_en, high_freq_ref, offset_up_en,
            offset_dn_en}, 5'h19);
        chk("rst_gain", {pump_up_gain, pump_down_gain, offset_magnitude}, 21'h19_3200);
    endtask
    initial begin
        rst();
        frame(0, 6'h08, 0, 0);
        chk("analog_bias_enable", rd, 32'h00c1_beff);
        frame(0, 6'h09, 0, 0);
        chk("charge_pump_control", rd, 32'h0040_3264);
        foreach (rows[i]) begin
            frame(1, rows[i][29:24], 0, rows[i][23:0]);
            frame(0, rows[i][29:24], 0, 0);
            chk("readback", rd, {8'h00, rows[i][23:0]});
            if (rows[i][29:24] == 6'h09) begin
                chk("dn", pump_down_gain, rows[i][6:0]);
                chk("up", pump_up_gain, rows[i][13:7]);
                chk("ofs", offset_magnitude, rows[i][20:14]);
                chk("dir", {offset_dn_en, offset_up_en}, rows[i][22:21]);
            end else begin
                chk("bias", {high_freq_ref, vco_bias_en, prescaler_clk_en},
                    {rows[i][21], rows[i][10:9]});
            end
        end
        c0 = rel_cnt;
        frame(1, 6'h09, 3'h5, 24'h00_0011);
        chk("released", rel_cnt > c0, 1);
        frame(0, 6'h09, 0, 0);
        chk("foreign", rd, 32'h001f_c07f);
        frame(1, 6'h0f, 0, 24'h00_0080);
        c0 = rel_cnt;
        frame(1, 6'h09, 3'h5, 24'h00_0011);
        chk("held", rel_cnt - c0, 0);
        frame(1, 6'h0f, 0, 24'h00_0000);
        frame(1, 6'h08, 0, 24'h3e_4100);
        chk("drv_off", serial_out_driver, 0);
        chk("pin_off", pbcp_if_inst.sdo_oe, 0);
        frame(1, 6'h08, 0, 24'hc1_beff);
        lock_flag <= 1;
        repeat (4) @(posedge pclk);
        chk("lock", pbcp_if_inst.sdo_pin, 1);
        chk("lock_pin", lock_or_serial_out_pin, 1);
        frame(0, 6'h08, 0, 0);
        repeat (4) @(posedge pclk);
        chk("lock_back", pbcp_if_inst.sdo_pin, 1);
        apb(0, 12'h010, 0);
        chk("slverr", err, 1);
        rst();
        wrap_up();
    end
endmodule
`default_nettype wire
